// >>> otos_pkg.sv
// package for the output turn-on sequencer: command codes, field layout,
// reset values, state encoding and the command request carrier.
// assumes a PMBus front end in the same clock domain decodes each transfer.
package otos_pkg;

  // command codes, also the register offsets
  localparam logic [7:0] OTOS_CMD_OK_ASSERT = 8'h5E;
  localparam logic [7:0] OTOS_CMD_OK_RELEASE = 8'h5F;
  localparam logic [7:0] OTOS_CMD_WAIT_TIME = 8'h60;
  localparam logic [7:0] OTOS_CMD_RAMP_TIME = 8'h61;
  localparam logic [7:0] OTOS_CMD_TO_LIMIT = 8'h62;
  localparam logic [7:0] OTOS_CMD_TO_ACTION = 8'h63;

  // reset values
  localparam logic [15:0] OTOS_RST_OK_ASSERT = 16'h0000;
  localparam logic [15:0] OTOS_RST_OK_RELEASE = 16'h0000;
  localparam logic [15:0] OTOS_RST_WAIT_TIME = 16'h0000;
  localparam logic [15:0] OTOS_RST_RAMP_TIME = 16'h0000;
  localparam logic [15:0] OTOS_RST_TO_LIMIT = 16'h0000;
  localparam logic [7:0] OTOS_RST_TO_ACTION = 8'h00;

  // timeout action byte fields
  localparam int OTOS_RESP_MSB = 7;
  localparam int OTOS_RESP_LSB = 6;
  localparam int OTOS_RETRY_MSB = 5;
  localparam int OTOS_RETRY_LSB = 3;
  localparam int OTOS_DELAY_MSB = 2;
  localparam int OTOS_DELAY_LSB = 0;

  // response codes
  localparam logic [1:0] OTOS_RESP_IGNORE = 2'h0;
  localparam logic [1:0] OTOS_RESP_RUN_ON = 2'h1;
  localparam logic [1:0] OTOS_RESP_DISABLE = 2'h2;
  localparam logic [1:0] OTOS_RESP_LATCH = 2'h3;

  // retry codes
  localparam logic [2:0] OTOS_RETRY_NONE = 3'h0;
  localparam logic [2:0] OTOS_RETRY_ENDLESS = 3'h7;

  // timing
  localparam int OTOS_CLK_HZ = 50000000;
  localparam int OTOS_MS_PER_S = 1000;

  typedef enum logic [6:0] {
    OTOS_OFF = 7'h01,
    OTOS_WAIT = 7'h02,
    OTOS_RAMP = 7'h04,
    OTOS_ON = 7'h08,
    OTOS_HOLD = 7'h10,
    OTOS_RETRY = 7'h20,
    OTOS_LATCH = 7'h40
  } otos_state_type;

  // one decoded PMBus transfer
  typedef struct packed {
    logic [7:0] code;
    logic write;
    logic read;
    logic word;
    logic [15:0] data;
  } otos_cmd_type;

endpackage

// >>> otos_sequencer.sv
// output turn-on sequencer: command registers, turn-on delay and ramp,
// power-up timeout with its fault response and retries, power-good hysteresis.
// assumes the PMBus decoder and the output-voltage reading share clk_in;
// only the control pin comes from outside and is synchronised.
`timescale 1ns/1ps
module otos_sequencer
  import otos_pkg::*;
#(
  parameter int CYCLES_PER_MS = OTOS_CLK_HZ / OTOS_MS_PER_S,
  parameter logic [15:0] FAULT_UNIT_MS = 16'h0001
)
(
  input wire logic clk_in, // 50 MHz clock
  input wire logic rst_n_in, // async reset, active low
  input wire otos_cmd_type cmd_in, // decoded transfer, one-cycle strobes
  input wire logic enable_pin_in, // control pin, asynchronous
  input wire logic [15:0] vout_in, // output voltage reading, vout mode
  input wire logic [15:0] uv_limit_in, // undervoltage fault limit
  input wire logic ok_pin_enable_in, // multi_function_pin_setup power good enable
  input wire logic clear_faults_in, // clear all faults pulse
  input wire logic clear_timeout_in, // clear timeout bit pulse
  output logic [15:0] rd_data_out, // read data
  output logic cmd_ack_out, // transfer accepted pulse
  output logic cmd_error_out, // transfer refused pulse
  output logic output_ok_signal_out, // power good pin
  output logic ok_status_out, // power good status bit, 1 = not good
  output logic output_enable_out, // converter output enabled
  output logic ramp_active_out, // output voltage ramping
  output logic timeout_fault_out, // sticky power-up timeout fault
  output logic [2:0] attempts_out // restart attempts done
);

  // command registers
  logic [15:0] ok_assert_reg;
  logic [15:0] ok_release_reg;
  logic [15:0] wait_time_reg;
  logic [15:0] ramp_time_reg;
  logic [15:0] to_limit_reg;
  logic [7:0] to_action_reg;

  // transfer decode
  wire hit_word = (cmd_in.code >= OTOS_CMD_OK_ASSERT) && (cmd_in.code <= OTOS_CMD_TO_LIMIT);
  wire hit_byte = (cmd_in.code == OTOS_CMD_TO_ACTION);
  wire access = cmd_in.write | cmd_in.read;
  wire size_ok = (hit_word && cmd_in.word) || (hit_byte && !cmd_in.word);
  wire cmd_good = access && size_ok;
  wire wr_good = cmd_in.write && size_ok;
  wire wr_assert = wr_good && (cmd_in.code == OTOS_CMD_OK_ASSERT);
  wire wr_release = wr_good && (cmd_in.code == OTOS_CMD_OK_RELEASE);
  wire wr_wait = wr_good && (cmd_in.code == OTOS_CMD_WAIT_TIME);
  wire wr_ramp = wr_good && (cmd_in.code == OTOS_CMD_RAMP_TIME);
  wire wr_limit = wr_good && (cmd_in.code == OTOS_CMD_TO_LIMIT);
  wire wr_action = wr_good && hit_byte;

  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (cmd_in.code)
      OTOS_CMD_OK_ASSERT: rd_mux = ok_assert_reg;
      OTOS_CMD_OK_RELEASE: rd_mux = ok_release_reg;
      OTOS_CMD_WAIT_TIME: rd_mux = wait_time_reg;
      OTOS_CMD_RAMP_TIME: rd_mux = ramp_time_reg;
      OTOS_CMD_TO_LIMIT: rd_mux = to_limit_reg;
      OTOS_CMD_TO_ACTION: rd_mux = {8'h00, to_action_reg};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ok_assert_reg <= OTOS_RST_OK_ASSERT;
      ok_release_reg <= OTOS_RST_OK_RELEASE;
      wait_time_reg <= OTOS_RST_WAIT_TIME;
      ramp_time_reg <= OTOS_RST_RAMP_TIME;
      to_limit_reg <= OTOS_RST_TO_LIMIT;
      to_action_reg <= OTOS_RST_TO_ACTION;
    end
    else
    begin
      if (wr_assert)
        ok_assert_reg <= cmd_in.data;
      if (wr_release)
        ok_release_reg <= cmd_in.data;
      if (wr_wait)
        wait_time_reg <= cmd_in.data;
      if (wr_ramp)
        ramp_time_reg <= cmd_in.data;
      if (wr_limit)
        to_limit_reg <= cmd_in.data;
      if (wr_action)
        to_action_reg <= cmd_in.data[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out <= 16'h0000;
      cmd_ack_out <= 1'b0;
      cmd_error_out <= 1'b0;
    end
    else
    begin
      rd_data_out <= (cmd_in.read && size_ok) ? rd_mux : 16'h0000;
      cmd_ack_out <= cmd_good;
      cmd_error_out <= access && !size_ok;
    end
  end

  // control pin synchroniser
  logic en_meta_reg;
  logic en_sync_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end
    else
    begin
      en_meta_reg <= enable_pin_in;
      en_sync_reg <= en_meta_reg;
    end
  end

  // millisecond tick; divider kept wide enough for the default rate
  logic [31:0] div_reg;
  wire ms_tick = (div_reg == 32'(CYCLES_PER_MS - 1));
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      div_reg <= 32'h00000000;
    else
      div_reg <= ms_tick ? 32'h00000000 : div_reg + 32'h00000001;
  end

  // action byte fields
  wire [1:0] resp_code = to_action_reg[OTOS_RESP_MSB:OTOS_RESP_LSB];
  wire [2:0] retry_code = to_action_reg[OTOS_RETRY_MSB:OTOS_RETRY_LSB];
  wire [2:0] delay_code = to_action_reg[OTOS_DELAY_MSB:OTOS_DELAY_LSB];
  wire [15:0] fault_delay_ms = FAULT_UNIT_MS << delay_code;

  otos_state_type state_reg;
  otos_state_type state_next;
  logic [15:0] ms_cnt_reg;
  logic [15:0] to_cnt_reg;
  logic reached_reg;
  logic to_seen_reg;
  logic [2:0] attempts_reg;

  wire uv_ok = (vout_in >= uv_limit_in);
  wire powering = (state_reg == OTOS_WAIT) || (state_reg == OTOS_RAMP) || (state_reg == OTOS_ON);
  // a timeout fires once per attempt; limit zero never fires
  wire to_event = powering && !reached_reg && !uv_ok && !to_seen_reg
    && (to_limit_reg != 16'h0000) && (to_cnt_reg >= to_limit_reg);
  wire fault_clear = clear_faults_in || clear_timeout_in;
  wire retry_left = (retry_code == OTOS_RETRY_ENDLESS) || (attempts_reg < retry_code);
  wire retry_ok = (retry_code != OTOS_RETRY_NONE) && retry_left;
  wire [6:0] retry_target = retry_ok ? OTOS_RETRY : OTOS_LATCH; // carries a whole state code
  wire wait_done = (ms_cnt_reg >= wait_time_reg);
  wire ramp_done = (ms_cnt_reg >= ramp_time_reg);
  wire fault_wait_done = (ms_cnt_reg >= fault_delay_ms);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      OTOS_OFF:
        if (en_sync_reg)
          state_next = OTOS_WAIT;
      OTOS_WAIT:
        if (to_event && resp_code != OTOS_RESP_IGNORE)
          state_next = OTOS_HOLD;
        else if (wait_done)
          state_next = OTOS_RAMP;
      OTOS_RAMP:
        if (to_event && resp_code != OTOS_RESP_IGNORE)
          state_next = OTOS_HOLD;
        else if (ramp_done)
          state_next = OTOS_ON;
      OTOS_ON:
        if (to_event && resp_code != OTOS_RESP_IGNORE)
          state_next = OTOS_HOLD;
      OTOS_HOLD:
        // entered on the fault; response decides how it leaves
        unique case (resp_code)
          OTOS_RESP_RUN_ON:
            if (fault_wait_done)
              state_next = (uv_ok || reached_reg) ? OTOS_ON : otos_state_type'(retry_target);
          OTOS_RESP_DISABLE:
            state_next = otos_state_type'(retry_target);
          OTOS_RESP_LATCH:
            state_next = OTOS_LATCH;
          OTOS_RESP_IGNORE:
            state_next = OTOS_ON;
        endcase
      OTOS_RETRY:
        if (fault_wait_done)
          state_next = OTOS_WAIT;
      OTOS_LATCH:
        if (fault_clear)
          state_next = OTOS_OFF;
      default:
        state_next = OTOS_OFF;
    endcase
    if (!en_sync_reg)
      state_next = OTOS_OFF;
  end

  wire state_change = (state_next != state_reg);
  wire restart = (state_reg == OTOS_RETRY) && (state_next == OTOS_WAIT);
  wire fresh_start = (state_reg == OTOS_OFF) && (state_next == OTOS_WAIT);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= OTOS_OFF;
      ms_cnt_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_change)
        ms_cnt_reg <= 16'h0000;
      else if (ms_tick && ms_cnt_reg != 16'hFFFF)
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  // power-up timer, restarted with every full turn-on sequence
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      to_cnt_reg <= 16'h0000;
      reached_reg <= 1'b0;
      to_seen_reg <= 1'b0;
    end
    else if (fresh_start || restart)
    begin
      to_cnt_reg <= 16'h0000;
      reached_reg <= 1'b0;
      to_seen_reg <= 1'b0;
    end
    else
    begin
      if (ms_tick && powering && to_cnt_reg != 16'hFFFF)
        to_cnt_reg <= to_cnt_reg + 16'h0001;
      if (powering && uv_ok)
        reached_reg <= 1'b1;
      if (to_event)
        to_seen_reg <= 1'b1;
    end
  end

  // attempts: only counted when a full sequence is reinitiated
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      attempts_reg <= 3'h0;
    else if (state_reg == OTOS_OFF)
      attempts_reg <= 3'h0;
    else if (restart && attempts_reg != 3'h7)
      attempts_reg <= attempts_reg + 3'h1;
  end

  // sticky fault: a new event beats a clear in the same cycle
  logic fault_reg;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      fault_reg <= 1'b0;
    else if (to_event)
      fault_reg <= 1'b1;
    else if (fault_clear || !en_sync_reg)
      fault_reg <= 1'b0;
  end

  // power good with hysteresis; judged only while the output is on
  logic good_reg;
  wire out_on = (state_reg == OTOS_RAMP) || (state_reg == OTOS_ON) || (state_reg == OTOS_HOLD);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      good_reg <= 1'b0;
    else if (!out_on || vout_in < ok_release_reg)
      good_reg <= 1'b0;
    else if (vout_in >= ok_assert_reg)
      good_reg <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      output_ok_signal_out <= 1'b0;
      ok_status_out <= 1'b1;
      output_enable_out <= 1'b0;
      ramp_active_out <= 1'b0;
      timeout_fault_out <= 1'b0;
      attempts_out <= 3'h0;
    end
    else
    begin
      output_ok_signal_out <= good_reg && ok_pin_enable_in;
      ok_status_out <= !good_reg;
      output_enable_out <= out_on;
      ramp_active_out <= (state_reg == OTOS_RAMP);
      timeout_fault_out <= fault_reg;
      attempts_out <= attempts_reg;
    end
  end

endmodule

// >>> otos_monitor.sv
// checker for the turn-on sequencer, bound to its ports
// assumes one clock domain; shadows the written thresholds and action byte
`timescale 1ns/1ps
module otos_monitor
  import otos_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire otos_cmd_type cmd_in, // transfer
  input wire logic enable_pin_in, // control pin
  input wire logic [15:0] vout_in, // voltage
  input wire logic [15:0] uv_limit_in, // uv limit
  input wire logic ok_pin_enable_in, // pin enable
  input wire logic clear_faults_in, // clear all
  input wire logic clear_timeout_in, // clear bit
  input wire logic [15:0] rd_data_out, // read data
  input wire logic cmd_ack_out, // accepted
  input wire logic cmd_error_out, // refused
  input wire logic output_ok_signal_out, // good pin
  input wire logic ok_status_out, // status bit
  input wire logic output_enable_out, // output on
  input wire logic ramp_active_out, // ramping
  input wire logic timeout_fault_out, // fault
  input wire logic [2:0] attempts_out // attempts
);
  logic [15:0] asrt_reg;
  logic [15:0] rel_reg;
  logic [15:0] lim_reg;
  logic [7:0] act_reg;
  wire strobe = cmd_in.write | cmd_in.read;
  wire word_code = cmd_in.code >= OTOS_CMD_OK_ASSERT && cmd_in.code <= OTOS_CMD_TO_LIMIT;
  wire legal = word_code ? cmd_in.word : cmd_in.code == OTOS_CMD_TO_ACTION && !cmd_in.word;
  wire [1:0] resp = act_reg[OTOS_RESP_MSB:OTOS_RESP_LSB];
  wire [2:0] retry = act_reg[OTOS_RETRY_MSB:OTOS_RETRY_LSB];
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      asrt_reg <= OTOS_RST_OK_ASSERT;
      rel_reg <= OTOS_RST_OK_RELEASE;
      lim_reg <= OTOS_RST_TO_LIMIT;
      act_reg <= OTOS_RST_TO_ACTION;
    end
    else if (strobe && cmd_in.write && legal)
    begin
      case (cmd_in.code)
        OTOS_CMD_OK_ASSERT: asrt_reg <= cmd_in.data;
        OTOS_CMD_OK_RELEASE: rel_reg <= cmd_in.data;
        OTOS_CMD_TO_LIMIT: lim_reg <= cmd_in.data;
        OTOS_CMD_TO_ACTION: act_reg <= cmd_in.data[7:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_new_fault;
    $rose(timeout_fault_out);
  endsequence
  sequence s_steady_pin;
    enable_pin_in [*3];
  endsequence
  a_ack_legal:
  assert property (strobe && legal |=> cmd_ack_out && !cmd_error_out)
    else $error("legal transfer not acknowledged");
  a_refuse_size:
  assert property (strobe && !legal |=> cmd_error_out && !cmd_ack_out && rd_data_out == 16'h0000)
    else $error("bad transfer not refused");
  a_good_level:
  assert property ($rose(output_ok_signal_out) && $past(ok_status_out) |-> $past(vout_in, 2) >= $past(asrt_reg, 2))
    else $error("power good rose below assert level");
  a_drop_below:
  assert property (output_ok_signal_out && vout_in < rel_reg |-> ##[1:3] !output_ok_signal_out)
    else $error("power good kept below release level");
  a_zero_limit:
  assert property (lim_reg == 16'h0000 && !timeout_fault_out |=> !timeout_fault_out)
    else $error("timeout fired with zero limit");
  a_ignore_runs:
  assert property (s_new_fault ##0 (resp == OTOS_RESP_IGNORE && output_enable_out) |-> output_enable_out [*4])
    else $error("ignored fault interrupted output");
  a_disable_now:
  assert property (s_new_fault ##0 resp[1] |-> ##[1:3] !output_enable_out)
    else $error("output not disabled on fault");
  a_attempt_cap:
  assert property (retry != OTOS_RETRY_ENDLESS |-> attempts_out <= retry)
    else $error("too many restart attempts");
  a_fault_sticky:
  // the fault output lags its flag by one edge, so clears count one edge back and the pin, through its two-flop synchroniser, three
  assert property (s_steady_pin ##1 (timeout_fault_out && !$past(clear_faults_in) && !$past(clear_timeout_in))
    |=> timeout_fault_out)
    else $error("fault cleared without cause");
endmodule
bind otos_sequencer otos_monitor otos_monitor_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
  .enable_pin_in(enable_pin_in), .vout_in(vout_in), .uv_limit_in(uv_limit_in), .ok_pin_enable_in(ok_pin_enable_in),
  .clear_faults_in(clear_faults_in), .clear_timeout_in(clear_timeout_in), .rd_data_out(rd_data_out),
  .cmd_ack_out(cmd_ack_out), .cmd_error_out(cmd_error_out), .output_ok_signal_out(output_ok_signal_out),
  .ok_status_out(ok_status_out), .output_enable_out(output_enable_out), .ramp_active_out(ramp_active_out),
  .timeout_fault_out(timeout_fault_out), .attempts_out(attempts_out));

// >>> otos_host.sv
// host controller model issuing decoded command transfers
// assumes the device answers one clock after each strobe
`timescale 1ns/1ps
module otos_host
  import otos_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic [15:0] rd_data_in, // read data
  input wire logic ack_in, // accepted
  input wire logic err_in, // refused
  output otos_cmd_type cmd_out // transfer
);
  initial cmd_out = '0;
  // size flag comes from the caller so wrong sizes can be sent on purpose
  task automatic xfer(input logic w, input logic [7:0] c, input logic s, input logic [15:0] d,
    output logic [15:0] r, output logic a, output logic e);
  begin
    @(posedge clk_in);
    cmd_out <= '{c, w, !w, s, d};
    @(posedge clk_in);
    cmd_out <= '0;
    #1;
    r = rd_data_in;
    a = ack_in;
    e = err_in;
  end
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the turn-on sequencer
// assumes a 50 MHz clock and a millisecond shortened to 4 cycles
`timescale 1ns/1ps
module testbench
  import otos_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  otos_cmd_type cmd_in;
  logic enable_pin_in = 1'b0;
  logic [15:0] vout_in = 16'h0000;
  logic [15:0] uv_limit_in = 16'h0050;
  logic ok_pin_enable_in = 1'b1;
  logic clear_faults_in = 1'b0;
  logic clear_timeout_in = 1'b0;
  logic [15:0] rd_data_out;
  logic cmd_ack_out, cmd_error_out, output_ok_signal_out, ok_status_out;
  logic output_enable_out, ramp_active_out, timeout_fault_out;
  logic [2:0] attempts_out;
  int fails = 0;
  int compares = 0;
  int n;
  logic [15:0] rd;
  logic [15:0] p;
  logic [7:0] c;
  logic ack;
  logic err;
  logic [7:0] acts [5] = '{8'h10, 8'h50, 8'h90, 8'hD0, 8'h80};
  logic [2:0] atts [5] = '{3'h0, 3'h2, 3'h2, 3'h0, 3'h0};
  always #10 clk_in = ~clk_in;
  otos_sequencer #(.CYCLES_PER_MS(4), .FAULT_UNIT_MS(16'h0001)) otos_sequencer_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .cmd_in(cmd_in), .enable_pin_in(enable_pin_in), .vout_in(vout_in),
    .uv_limit_in(uv_limit_in), .ok_pin_enable_in(ok_pin_enable_in), .clear_faults_in(clear_faults_in),
    .clear_timeout_in(clear_timeout_in), .rd_data_out(rd_data_out), .cmd_ack_out(cmd_ack_out),
    .cmd_error_out(cmd_error_out), .output_ok_signal_out(output_ok_signal_out), .ok_status_out(ok_status_out),
    .output_enable_out(output_enable_out), .ramp_active_out(ramp_active_out),
    .timeout_fault_out(timeout_fault_out), .attempts_out(attempts_out));
  otos_host otos_host_inst (.clk_in(clk_in), .rd_data_in(rd_data_out), .ack_in(cmd_ack_out),
    .err_in(cmd_error_out), .cmd_out(cmd_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic s, input logic [15:0] d);
    otos_host_inst.xfer(w, a, s, d, rd, ack, err);
  endtask
  task automatic setr(input logic [7:0] a, input logic [15:0] d);
    xf(1'b1, a, a != OTOS_CMD_TO_ACTION, d);
  endtask
  task automatic cyc(input int k);
  begin
    repeat (k) @(posedge clk_in);
    #1;
  end
  endtask
  task automatic wrap_up;
  begin
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    fails++;
    wrap_up();
  end
  initial
  begin
    cyc(4);
    rst_n_in <= 1'b1;
    cyc(1);
    for (int i = 0; i < 7; i++)
    begin
      c = OTOS_CMD_OK_ASSERT + 8'(i);
      p = 16'hA5C3 ^ 16'(i);
      xf(1'b0, c, i < 5, 16'h0000);
      chk(rd, 16'h0000);
      chk({15'h0000, err}, {15'h0000, i == 6});
      xf(1'b1, c, i < 5, p);
      chk({14'h0000, ack, err}, i < 6 ? 16'h0002 : 16'h0001);
      xf(1'b1, c, i == 5, 16'hFFFF);
      chk({15'h0000, err}, 16'h0001);
      xf(1'b0, c, i < 5, 16'h0000);
      chk(rd, i < 5 ? p : i == 5 ? {8'h00, p[7:0]} : 16'h0000);
    end
    setr(OTOS_CMD_OK_ASSERT, 16'h0100);
    setr(OTOS_CMD_OK_RELEASE, 16'h0080);
    setr(OTOS_CMD_TO_LIMIT, 16'h0000);
    setr(OTOS_CMD_WAIT_TIME, 16'h0000);
    setr(OTOS_CMD_RAMP_TIME, 16'h0000);
    setr(OTOS_CMD_TO_ACTION, 16'h00C0);
    enable_pin_in <= 1'b1;
    cyc(200);
    chk({14'h0000, timeout_fault_out, output_enable_out}, 16'h0001);
    vout_in <= 16'h0120;
    cyc(10);
    chk({14'h0000, output_ok_signal_out, ok_status_out}, 16'h0002);
    vout_in <= 16'h00A0;
    cyc(10);
    chk({14'h0000, output_ok_signal_out, ok_status_out}, 16'h0002);
    vout_in <= 16'h0070;
    cyc(10);
    chk({14'h0000, output_ok_signal_out, ok_status_out}, 16'h0001);
    vout_in <= 16'h0120;
    ok_pin_enable_in <= 1'b0;
    cyc(10);
    chk({14'h0000, output_ok_signal_out, ok_status_out}, 16'h0000);
    ok_pin_enable_in <= 1'b1;
    enable_pin_in <= 1'b0;
    cyc(10);
    setr(OTOS_CMD_WAIT_TIME, 16'h0003);
    setr(OTOS_CMD_RAMP_TIME, 16'h0002);
    enable_pin_in <= 1'b1;
    for (n = 0; ramp_active_out !== 1'b1 && n < 100; n++)
      cyc(1);
    chk(16'(n >= 10 && n <= 20), 16'h0001);
    for (n = 0; ramp_active_out === 1'b1 && n < 100; n++)
      cyc(1);
    chk(16'(n >= 4 && n <= 13), 16'h0001);
    chk({15'h0000, output_enable_out}, 16'h0001);
    enable_pin_in <= 1'b0;
    setr(OTOS_CMD_WAIT_TIME, 16'h0000);
    setr(OTOS_CMD_RAMP_TIME, 16'h0000);
    setr(OTOS_CMD_TO_LIMIT, 16'h0003);
    vout_in <= 16'h0000;
    // vout held at zero never reaches the uv limit, so every attempt times out
    for (int i = 0; i < 5; i++)
    begin
      cyc(10);
      setr(OTOS_CMD_TO_ACTION, {8'h00, acts[i]});
      enable_pin_in <= 1'b1;
      cyc(300);
      chk({15'h0000, timeout_fault_out}, 16'h0001);
      chk({15'h0000, output_enable_out}, {15'h0000, i == 0});
      chk({13'h0000, attempts_out}, {13'h0000, atts[i]});
      clear_faults_in <= i == 4;
      clear_timeout_in <= i == 3;
      cyc(1);
      clear_faults_in <= 1'b0;
      clear_timeout_in <= 1'b0;
      cyc(1);
      chk({15'h0000, timeout_fault_out}, {15'h0000, i < 3});
      enable_pin_in <= 1'b0;
    end
    cyc(10);
    // output reaches the uv limit in time, so no timeout may fire
    vout_in <= 16'h0120;
    enable_pin_in <= 1'b1;
    cyc(100);
    chk({14'h0000, timeout_fault_out, output_enable_out}, 16'h0001);
    cyc(10);
    wrap_up();
  end
endmodule
